// [common/data_memory_pkg.sv]
// shared constants and types for the data memory addressing block
package data_memory_pkg;

    // ------------------------------------------------------------
    // operation requests from the instruction sequencer
    // ------------------------------------------------------------
    typedef enum logic [3:0]
    {
        OP_PUSH,
        OP_POP,
        OP_CALL,
        OP_INT_RET,
        OP_INC_IND,
        OP_DEC_REG,
        OP_BIT_CLR,
        OP_BIT_SET,
        OP_BIT_CPL,
        OP_BIT_TEST,
        OP_BIT_MOVE,
        OP_DIR_READ,
        OP_DIR_WRITE
    } op_t;

    // ------------------------------------------------------------
    // sequencing states
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        S_IDLE,
        S_CALL_HI,
        S_POP,
        S_RET_HI,
        S_RET_LO,
        S_POINTER,
        S_MODIFY,
        S_READ
    } state_t;

    // ------------------------------------------------------------
    // memory geometry and addressing constants
    // ------------------------------------------------------------
    localparam int RAM_ADDR_W = 8;
    localparam int RAM_DEPTH = 256;
    localparam logic [7:0] STACK_RESET = 8'h07;
    localparam logic [7:0] BIT_RAM_BASE = 8'h20;
    localparam logic [7:0] SFR_SPACE_BASE = 8'h80;
    localparam logic [7:0] UNMAPPED_READ = 8'hff;
    localparam logic [7:0] SFR_RESET = 8'h00;
    localparam int DIRECT_SPACE_BIT = 7;
    localparam int BANK_LOW_POS = 3;
    localparam int BANK_HIGH_POS = 4;

    // ------------------------------------------------------------
    // special function register map, one entry per register
    // ------------------------------------------------------------
    localparam int SFR_COUNT = 27;
    localparam logic [7:0] SFR_ADDR [SFR_COUNT] = '{
        8'h80, 8'h81, 8'h82, 8'h83, 8'h87, 8'h88, 8'h89, 8'h8a, 8'h8b,
        8'h8c, 8'h8d, 8'h90, 8'h98, 8'h99, 8'ha0, 8'ha8, 8'hb0, 8'hb8,
        8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hd0, 8'he0, 8'hf0, 8'hf8
    };
    localparam logic [4:0] STACK_TOP_POINTER_IDX = 5'd1;
    localparam logic [4:0] PROGRAM_STATUS_IDX = 5'd23;

endpackage

// [src/data_ram.sv]
// single-port internal data memory with registered read data
`timescale 1ns/1ps
`default_nettype none

module data_ram
    import data_memory_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [RAM_ADDR_W-1:0] addr,
    input wire logic writeEn,
    input wire logic [7:0] writeData,
    output logic [7:0] readData
);

    logic [7:0] mem [RAM_DEPTH];

    // ------------------------------------------------------------
    // storage: contents carry no reset, as in a real ram macro
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (writeEn)
        begin
            mem[addr] <= writeData;
        end
    end

    // ------------------------------------------------------------
    // read port: data of the address given one edge earlier
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            readData <= 8'h00;
        end
        else
        begin
            readData <= mem[addr];
        end
    end

endmodule

`default_nettype wire

// [src/data_memory_addressing.sv]
// stack, working-register, bit and special function register addressing
`timescale 1ns/1ps
`default_nettype none

module data_memory_addressing
    import data_memory_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic opValid,
    output logic opReady,
    input wire op_t opCode,
    input wire logic [7:0] opOperand,
    input wire logic [7:0] opData,
    input wire logic [15:0] ctrIn,
    output logic resultValid,
    output logic [7:0] resultData,
    output logic resultBit,
    output logic ctrValid,
    output logic [15:0] ctrOut,
    output logic [7:0] stackPointer,
    output logic [1:0] activeBank
);

    // ------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------

    // maps a direct address onto the register array; bit 5 flags a hit
    function automatic logic [5:0] sfrLookup(input logic [7:0] address);
        logic [5:0] found;
        found = 6'h00;
        for (int i = 0; i < SFR_COUNT; i++)
        begin
            if (SFR_ADDR[i] == address)
            begin
                found = {1'b1, 5'(i)};
            end
        end
        return found;
    endfunction

    // applies one bit operation to a byte; test leaves the byte alone
    function automatic logic [7:0] bitApply(input op_t op, input logic [7:0] value,
                                            input logic [2:0] sel, input logic moveVal);
        logic [7:0] res;
        res = value;
        case (op)
            OP_BIT_CLR: res[sel] = 1'b0;
            OP_BIT_SET: res[sel] = 1'b1;
            OP_BIT_CPL: res[sel] = ~value[sel];
            OP_BIT_MOVE: res[sel] = moveVal;
            default: res = value;
        endcase
        return res;
    endfunction

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    state_t state_q;
    state_t state_d;
    op_t op_q;
    logic [7:0] sfr_q [SFR_COUNT];
    logic [7:0] tmpAddr_q;
    logic [7:0] tmpAddr_d;
    logic [2:0] bitSel_q;
    logic moveVal_q;
    logic [7:0] ctrHigh_q;
    logic [7:0] ramAddr;
    logic ramWe;
    logic [7:0] ramWdata;
    logic [7:0] ramRdata;
    logic [7:0] stk;
    logic [7:0] stkInc;
    logic [7:0] stkDec;
    logic stkWe;
    logic [7:0] stk_d;
    logic sfrWe;
    logic [4:0] sfrWidx;
    logic [7:0] sfrWdata;
    logic [5:0] byteHit;
    logic [5:0] bitHit;
    logic [7:0] byteRead;
    logic [7:0] bitByte;
    logic [7:0] bitRamAddr;
    logic [7:0] modified;
    logic loadOp;
    logic done_d;
    logic [7:0] resData_d;
    logic resBit_d;
    logic ctrHighWe;
    logic ctrLowWe;
    logic [1:0] bank;

    // ------------------------------------------------------------
    // address arithmetic
    // ------------------------------------------------------------

    // stack pointer and bank come straight from the register array
    assign stk = sfr_q[STACK_TOP_POINTER_IDX];
    assign stkInc = 8'(stk + 8'h01);
    assign stkDec = 8'(stk - 8'h01);
    assign bank = {sfr_q[PROGRAM_STATUS_IDX][BANK_HIGH_POS],
                   sfr_q[PROGRAM_STATUS_IDX][BANK_LOW_POS]};

    // byte access looks up the operand, bit access its aligned byte
    assign byteHit = sfrLookup(opOperand);
    assign bitHit = sfrLookup({opOperand[7:3], 3'b000});
    assign byteRead = byteHit[5] ? sfr_q[byteHit[4:0]] : UNMAPPED_READ;
    assign bitByte = bitHit[5] ? sfr_q[bitHit[4:0]] : UNMAPPED_READ;
    assign bitRamAddr = 8'(BIT_RAM_BASE + {4'h0, opOperand[6:3]});
    assign opReady = (state_q == S_IDLE);

    // result byte of the read-modify-write step
    always_comb
    begin
        case (op_q)
            OP_INC_IND: modified = 8'(ramRdata + 8'h01);
            OP_DEC_REG: modified = 8'(ramRdata - 8'h01);
            default: modified = bitApply(op_q, ramRdata, bitSel_q, moveVal_q);
        endcase
    end

    // ------------------------------------------------------------
    // sequencer: one request at a time, ram reads take one edge
    // ------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        ramAddr = stk;
        ramWe = 1'b0;
        ramWdata = opData;
        stkWe = 1'b0;
        stk_d = stk;
        sfrWe = 1'b0;
        sfrWidx = byteHit[4:0];
        sfrWdata = opData;
        tmpAddr_d = tmpAddr_q;
        loadOp = 1'b0;
        done_d = 1'b0;
        resData_d = 8'h00;
        resBit_d = 1'b0;
        ctrHighWe = 1'b0;
        ctrLowWe = 1'b0;
        case (state_q)
            S_IDLE:
            begin
                if (opValid)
                begin
                    loadOp = 1'b1;
                    case (opCode)
                        OP_PUSH:
                        begin
                            stk_d = stkInc;
                            stkWe = 1'b1;
                            ramAddr = stkInc;
                            ramWe = 1'b1;
                            done_d = 1'b1;
                        end
                        OP_CALL:
                        begin
                            stk_d = stkInc;
                            stkWe = 1'b1;
                            ramAddr = stkInc;
                            ramWe = 1'b1;
                            ramWdata = ctrIn[7:0];
                            state_d = S_CALL_HI;
                        end
                        OP_POP:
                        begin
                            ramAddr = stk;
                            state_d = S_POP;
                        end
                        OP_INT_RET:
                        begin
                            ramAddr = stk;
                            state_d = S_RET_HI;
                        end
                        OP_INC_IND:
                        begin
                            ramAddr = {3'b000, bank, 2'b00, opOperand[0]};
                            state_d = S_POINTER;
                        end
                        OP_DEC_REG:
                        begin
                            ramAddr = {3'b000, bank, opOperand[2:0]};
                            tmpAddr_d = {3'b000, bank, opOperand[2:0]};
                            state_d = S_MODIFY;
                        end
                        OP_DIR_READ:
                        begin
                            if (!opOperand[DIRECT_SPACE_BIT])
                            begin
                                ramAddr = opOperand;
                                state_d = S_READ;
                            end
                            else
                            begin
                                resData_d = byteRead;
                                done_d = 1'b1;
                            end
                        end
                        OP_DIR_WRITE:
                        begin
                            if (!opOperand[DIRECT_SPACE_BIT])
                            begin
                                ramAddr = opOperand;
                                ramWe = 1'b1;
                            end
                            else
                            begin
                                sfrWe = byteHit[5];
                            end
                            resData_d = opData;
                            done_d = 1'b1;
                        end
                        default:
                        begin
                            // the five bit operations
                            if (!opOperand[DIRECT_SPACE_BIT])
                            begin
                                ramAddr = bitRamAddr;
                                tmpAddr_d = bitRamAddr;
                                state_d = S_MODIFY;
                            end
                            else
                            begin
                                // unimplemented byte reads as ones, so a test sees 1
                                sfrWidx = bitHit[4:0];
                                sfrWdata = bitApply(opCode, bitByte, opOperand[2:0], opData[0]);
                                sfrWe = bitHit[5] && (opCode != OP_BIT_TEST);
                                resData_d = sfrWdata;
                                resBit_d = bitByte[opOperand[2:0]];
                                done_d = 1'b1;
                            end
                        end
                    endcase
                end
            end
            S_CALL_HI:
            begin
                stk_d = stkInc;
                stkWe = 1'b1;
                ramAddr = stkInc;
                ramWe = 1'b1;
                ramWdata = ctrHigh_q;
                done_d = 1'b1;
                state_d = S_IDLE;
            end
            S_POP:
            begin
                stk_d = stkDec;
                stkWe = 1'b1;
                resData_d = ramRdata;
                done_d = 1'b1;
                state_d = S_IDLE;
            end
            S_RET_HI:
            begin
                ctrHighWe = 1'b1;
                stk_d = stkDec;
                stkWe = 1'b1;
                ramAddr = stkDec;
                state_d = S_RET_LO;
            end
            S_RET_LO:
            begin
                ctrLowWe = 1'b1;
                stk_d = stkDec;
                stkWe = 1'b1;
                done_d = 1'b1;
                state_d = S_IDLE;
            end
            S_POINTER:
            begin
                // pointer register content addresses ram, never the sfr space
                ramAddr = ramRdata;
                tmpAddr_d = ramRdata;
                state_d = S_MODIFY;
            end
            S_MODIFY:
            begin
                ramAddr = tmpAddr_q;
                ramWe = (op_q != OP_BIT_TEST);
                ramWdata = modified;
                resData_d = modified;
                resBit_d = ramRdata[bitSel_q];
                done_d = 1'b1;
                state_d = S_IDLE;
            end
            S_READ:
            begin
                resData_d = ramRdata;
                done_d = 1'b1;
                state_d = S_IDLE;
            end
            default:
            begin
                state_d = S_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state and captured request fields
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= S_IDLE;
            op_q <= OP_PUSH;
            tmpAddr_q <= 8'h00;
            bitSel_q <= 3'b000;
            moveVal_q <= 1'b0;
            ctrHigh_q <= 8'h00;
        end
        else
        begin
            state_q <= state_d;
            tmpAddr_q <= tmpAddr_d;
            if (loadOp)
            begin
                op_q <= opCode;
                bitSel_q <= opOperand[2:0];
                moveVal_q <= opData[0];
                ctrHigh_q <= ctrIn[15:8];
            end
        end
    end

    // ------------------------------------------------------------
    // special function register array
    // ------------------------------------------------------------

    // stack updates come after byte writes; both never occur together
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < SFR_COUNT; i++)
            begin
                sfr_q[i] <= SFR_RESET;
            end
            sfr_q[STACK_TOP_POINTER_IDX] <= STACK_RESET;
        end
        else
        begin
            if (sfrWe)
            begin
                sfr_q[sfrWidx] <= sfrWdata;
            end
            if (stkWe)
            begin
                sfr_q[STACK_TOP_POINTER_IDX] <= stk_d;
            end
        end
    end

    // ------------------------------------------------------------
    // answers to the sequencer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            resultValid <= 1'b0;
            resultData <= 8'h00;
            resultBit <= 1'b0;
            ctrValid <= 1'b0;
            ctrOut <= 16'h0000;
        end
        else
        begin
            resultValid <= done_d;
            ctrValid <= ctrLowWe;
            if (done_d)
            begin
                resultData <= resData_d;
                resultBit <= resBit_d;
            end
            if (ctrHighWe)
            begin
                ctrOut[15:8] <= ramRdata;
            end
            if (ctrLowWe)
            begin
                ctrOut[7:0] <= ramRdata;
            end
        end
    end

    // observation outputs, straight from the register array
    assign stackPointer = stk;
    assign activeBank = bank;

    // ------------------------------------------------------------
    // internal ram
    // ------------------------------------------------------------
    data_ram data_ram_i
    (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .addr(ramAddr),
        .writeEn(ramWe),
        .writeData(ramWdata),
        .readData(ramRdata)
    );

endmodule

`default_nettype wire

// [dv/data_memory_addressing_props.sv]
// assertion checker for the data memory addressing block
`timescale 1ns/1ps
`default_nettype none

module data_memory_addressing_props
    import data_memory_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic opValid,
    input wire logic opReady,
    input wire op_t opCode,
    input wire logic [7:0] opOperand,
    input wire logic [7:0] opData,
    input wire logic resultValid,
    input wire logic [7:0] resultData,
    input wire logic ctrValid,
    input wire logic [7:0] stackPointer,
    input wire logic [1:0] activeBank
);
    // ------------------------------------------------------------
    // helper terms
    // ------------------------------------------------------------
    wire logic take = opValid && opReady;
    wire logic [1:0] bankField = opData[4:3];
    wire logic [2:0] bitSel = opOperand[2:0];

    // true when the address names one of the implemented registers
    function automatic logic mapped(input logic [7:0] a);
        logic hit;
        hit = 1'b0;
        for (int k = 0; k < SFR_COUNT; k++)
        begin
            if (SFR_ADDR[k] == a)
            begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    stack_reset_a: assert property ($rose(reset_n) |-> stackPointer == 8'h07)
        else $error("stack pointer not 07 after reset");
    push_step_a: assert property (take && opCode == OP_PUSH
        |=> resultValid && stackPointer == $past(stackPointer) + 8'h01)
        else $error("push did not advance pointer by one");
    pop_step_a: assert property (take && opCode == OP_POP
        |=> !opReady ##1 resultValid && stackPointer == $past(stackPointer, 2) - 8'h01)
        else $error("pop did not drop pointer by one");
    call_pair_a: assert property (take && opCode == OP_CALL
        |=> stackPointer == $past(stackPointer) + 8'h01
        ##1 resultValid && stackPointer == $past(stackPointer, 2) + 8'h02)
        else $error("call did not store two bytes");
    int_return_a: assert property (take && opCode == OP_INT_RET
        |-> ##3 ctrValid && resultValid && stackPointer == $past(stackPointer, 3) - 8'h02)
        else $error("return did not restore two bytes");
    ctr_with_result_a: assert property (ctrValid |-> resultValid)
        else $error("counter valid without result");
    inc_timing_a: assert property (take && opCode == OP_INC_IND
        |=> !resultValid [*2] ##1 resultValid)
        else $error("indirect increment latency wrong");
    dec_timing_a: assert property (take && opCode == OP_DEC_REG
        |=> !resultValid ##1 resultValid)
        else $error("register decrement latency wrong");
    bank_follow_a: assert property (take && opCode == OP_DIR_WRITE && opOperand == 8'hd0
        |=> activeBank == $past(bankField))
        else $error("bank select not taken from status write");
    unmapped_ff_a: assert property (take && opCode == OP_DIR_READ && opOperand[7]
        && !mapped(opOperand) |=> resultValid && resultData == 8'hff)
        else $error("unimplemented read not ff");
    bit_clear_a: assert property (take && opCode == OP_BIT_CLR && !opOperand[7]
        |-> ##2 resultValid && !resultData[$past(bitSel, 2)])
        else $error("cleared bit still set");

    call_seen_c: cover property (take && opCode == OP_CALL);
    return_seen_c: cover property (ctrValid);
    inc_seen_c: cover property (take && opCode == OP_INC_IND);
endmodule

bind data_memory_addressing data_memory_addressing_props data_memory_addressing_props_i (
    .core_clk(core_clk), .reset_n(reset_n), .opValid(opValid), .opReady(opReady),
    .opCode(opCode), .opOperand(opOperand), .opData(opData), .resultValid(resultValid),
    .resultData(resultData), .ctrValid(ctrValid), .stackPointer(stackPointer),
    .activeBank(activeBank));

`default_nettype wire

// [dv/sequencer_model.sv]
// instruction sequencer model issuing one request at a time
`timescale 1ns/1ps
`default_nettype none

module sequencer_model
    import data_memory_pkg::*;
(
    input wire logic core_clk,
    input wire logic opReady,
    input wire logic resultValid,
    input wire logic [7:0] resultData,
    input wire logic resultBit,
    input wire logic ctrValid,
    input wire logic [15:0] ctrOut,
    output logic opValid,
    output op_t opCode,
    output logic [7:0] opOperand,
    output logic [7:0] opData,
    output logic [15:0] ctrIn,
    output logic hung
);
    logic [7:0] rData;
    logic rBit;
    logic rCtrV;
    logic [15:0] rCtr;

    // idle request lines from time zero
    initial
    begin
        opValid = 1'b0;
        opCode = OP_DIR_READ;
        opOperand = 8'h00;
        opData = 8'h00;
        ctrIn = 16'h0000;
        hung = 1'b0;
    end

    // request held until taken, then wait for the result pulse
    task automatic issue(input op_t c, input logic [7:0] a, d, input logic [15:0] ctr);
        int n;
        @(posedge core_clk);
        #1;
        opValid = 1'b1;
        opCode = c;
        opOperand = a;
        opData = d;
        ctrIn = ctr;
        n = 0;
        while (opReady !== 1'b1 && n < 50)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        @(posedge core_clk);
        #1;
        // released lines show a changed pattern, not the stale request
        opValid = 1'b0;
        opOperand = ~a;
        opData = ~d;
        ctrIn = ~ctr;
        while (resultValid !== 1'b1 && n < 50)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        rData = resultData;
        rBit = resultBit;
        rCtrV = ctrValid;
        rCtr = ctrOut;
        if (n >= 50)
        begin
            hung = 1'b1;
        end
    endtask
endmodule

`default_nettype wire

// [dv/tb_data_memory_addressing.sv]
// self-checking bench for the data memory addressing block
`timescale 1ns/1ps
`default_nettype none

module tb_data_memory_addressing
    import data_memory_pkg::*;
;
    logic core_clk = 1'b0, reset_n = 1'b0;
    logic opValid, opReady, resultValid, resultBit, ctrValid, hung;
    op_t opCode;
    logic [7:0] opOperand, opData, resultData, stackPointer, a, e;
    logic [15:0] ctrIn, ctrOut;
    logic [1:0] activeBank;
    int nMismatch = 0;
    int totalChecks = 0;
    op_t bitOps [4] = '{OP_BIT_TEST, OP_BIT_SET, OP_BIT_CPL, OP_BIT_MOVE};
    logic [7:0] bitAdr [4] = '{8'h7f, 8'h7f, 8'h78, 8'h78};
    logic [7:0] bitByte [4] = '{8'h7f, 8'hff, 8'hfe, 8'hff};
    logic bitOld [4] = '{1'b0, 1'b0, 1'b1, 1'b0};

    // 200 MHz core clock
    always #2.5 core_clk = ~core_clk;

    data_memory_addressing data_memory_addressing_i (.core_clk(core_clk), .reset_n(reset_n),
        .opValid(opValid), .opReady(opReady), .opCode(opCode), .opOperand(opOperand),
        .opData(opData), .ctrIn(ctrIn), .resultValid(resultValid), .resultData(resultData),
        .resultBit(resultBit), .ctrValid(ctrValid), .ctrOut(ctrOut),
        .stackPointer(stackPointer), .activeBank(activeBank));
    sequencer_model sequencer_model_i (.core_clk(core_clk), .opReady(opReady),
        .resultValid(resultValid), .resultData(resultData), .resultBit(resultBit),
        .ctrValid(ctrValid), .ctrOut(ctrOut), .opValid(opValid), .opCode(opCode),
        .opOperand(opOperand), .opData(opData), .ctrIn(ctrIn), .hung(hung));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        totalChecks++;
        if (seen !== exp)
        begin
            nMismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic op(input op_t c, input logic [7:0] adr, d);
        sequencer_model_i.issue(c, adr, d, 16'h0000);
    endtask

    task automatic stopTest();
        $display("mismatches %0d checks %0d", nMismatch, totalChecks);
        if (nMismatch == 0 && totalChecks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // a stuck handshake ends the run as a failure
    always @(posedge hung)
    begin
        nMismatch++;
        stopTest();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge core_clk);
        #1 reset_n = 1'b1;
        check(stackPointer, 16'h0007);
        op(OP_DIR_READ, 8'h81, 8'h00);
        check(sequencer_model_i.rData, 16'h0007);
        // stack from 7fh crosses into upper ram, not the registers
        op(OP_DIR_WRITE, 8'h81, 8'h7f);
        sequencer_model_i.issue(OP_CALL, 8'h00, 8'h00, 16'h12c4);
        check(stackPointer, 16'h0081);
        op(OP_PUSH, 8'h00, 8'ha5);
        check(stackPointer, 16'h0082);
        op(OP_POP, 8'h00, 8'h00);
        check(sequencer_model_i.rData, 16'h00a5);
        op(OP_POP, 8'h00, 8'h00);
        check(sequencer_model_i.rData, 16'h0012);
        op(OP_PUSH, 8'h00, 8'h12);
        op(OP_INT_RET, 8'h00, 8'h00);
        check(sequencer_model_i.rCtr, 16'h12c4);
        check({15'h0000, sequencer_model_i.rCtrV}, 16'h0001);
        check(stackPointer, 16'h007f);
        // every register of every bank, including 00 wrapping to ff
        for (int b = 0; b < 4; b++)
        begin
            op(OP_DIR_WRITE, 8'hd0, 8'(b * 8));
            check(activeBank, 16'(b));
            for (int r = 0; r < 8; r++)
            begin
                a = 8'(b * 8 + r);
                op(OP_DIR_WRITE, a, a);
                op(OP_DEC_REG, 8'h18 | 8'(r), 8'h00);
                op(OP_DIR_READ, a, 8'h00);
                check(sequencer_model_i.rData, 16'(8'(a - 8'h01)));
            end
        end
        // indirect through bank 2 pointers, ff wraps to 00
        op(OP_DIR_WRITE, 8'hd0, 8'h10);
        op(OP_DIR_WRITE, 8'h10, 8'h30);
        op(OP_DIR_WRITE, 8'h11, 8'h31);
        op(OP_DIR_WRITE, 8'h30, 8'hff);
        op(OP_DIR_WRITE, 8'h31, 8'h07);
        op(OP_INC_IND, 8'h06, 8'h00);
        check(sequencer_model_i.rData, 16'h0000);
        op(OP_INC_IND, 8'h07, 8'h00);
        op(OP_DIR_READ, 8'h31, 8'h00);
        check(sequencer_model_i.rData, 16'h0008);
        // one bit cleared in each bit-addressable ram byte
        for (int i = 0; i < 16; i++)
        begin
            a = 8'(32 + i);
            op(OP_DIR_WRITE, a, 8'hff);
            op(OP_BIT_CLR, 8'(i * 8 + i % 8), 8'h00);
            check({15'h0000, sequencer_model_i.rBit}, 16'h0001);
            op(OP_DIR_READ, a, 8'h00);
            check(sequencer_model_i.rData, 16'(8'hff ^ (8'h01 << (i % 8))));
        end
        for (int j = 0; j < 4; j++)
        begin
            op(bitOps[j], bitAdr[j], 8'h01);
            check(sequencer_model_i.rData, 16'(bitByte[j]));
            check({15'h0000, sequencer_model_i.rBit}, {15'h0000, bitOld[j]});
        end
        // every implemented register by byte, aligned ones by bit too
        for (int k = 0; k < SFR_COUNT; k++)
        begin
            a = SFR_ADDR[k];
            e = a ^ 8'h3c;
            op(OP_DIR_WRITE, a, e);
            op(OP_DIR_READ, a, 8'h00);
            check(sequencer_model_i.rData, 16'(e));
            if (a[2:0] == 3'h0)
            begin
                op(OP_BIT_SET, a | 8'h05, 8'h00);
                check(sequencer_model_i.rData, 16'(e | 8'h20));
            end
        end
        op(OP_DIR_WRITE, 8'h84, 8'h12);
        op(OP_DIR_READ, 8'h84, 8'h00);
        check(sequencer_model_i.rData, 16'h00ff);
        check(stackPointer, 16'h00bd);
        op(OP_DIR_READ, 8'h80, 8'h00);
        check(sequencer_model_i.rData, 16'h00bc);
        op(OP_BIT_TEST, 8'hc3, 8'h00);
        check({15'h0000, sequencer_model_i.rBit}, 16'h0001);
        stopTest();
    end
endmodule

`default_nettype wire
